// ### verilog/dcfm_top.v
`timescale 1ns/1ps
`include "dcfm_regs.vh"
module dcfm_top #(
  parameter DATA_W = `DCFM_DATA_W,
  parameter DEPTH = `DCFM_DEPTH,
  parameter ADDR_W = 9
) (
  input wire clock,
  input wire sys_rst,
  input wire portAClock,
  input wire portBClock,
  input wire portASelectN,
  input wire portBSelectN,
  input wire portAWriteNotRead,
  input wire portBReadNotWrite,
  input wire portAGate,
  input wire portBGate,
  input wire portAMailSelect,
  input wire portBMailSelect,
  input wire offsetSel0SerialBit,
  input wire offsetSel1SerialLoadN,
  input wire [DATA_W-1:0] portADataIn,
  output reg [DATA_W-1:0] portADataOut,
  output reg portADataOe,
  input wire [DATA_W-1:0] portBDataIn,
  output reg [DATA_W-1:0] portBDataOut,
  output reg portBDataOe,
  output reg inputReady,
  output reg outputReady,
  output reg almostEmptyFlagN,
  output reg almostFullFlagN,
  output reg mailToBFlagN,
  output reg mailToAFlagN
);
  localparam ST_WAIT = 4'h1;
  localparam ST_SERIAL = 4'h2;
  localparam ST_PARALLEL = 4'h4;
  localparam ST_RUN = 4'h8;

  // offset mode codes as {select1, select0} caught in reset
  localparam STRAP_PARALLEL = 2'h0;
  localparam STRAP_LOW = 2'h1;
  localparam STRAP_HIGH = 2'h2;
  localparam STRAP_SERIAL = 2'h3;

  reg [3:0] initState;
  reg [1:0] startEdges;
  reg [4:0] serialBits;
  reg parallelDone;
  reg [1:0] strap;
  reg aClockPrev;
  reg bClockPrev;
  reg [`DCFM_OFS_W-1:0] emptyOffset;
  reg [`DCFM_OFS_W-1:0] fullOffset;
  reg [DATA_W-1:0] mailToB;
  reg [DATA_W-1:0] mailToA;
  reg [DATA_W-1:0] outReg;
  reg irStage;
  reg afStage;
  reg aeStage;
  reg orStage;
  wire aEdge;
  wire bEdge;
  wire aWriteCycle;
  wire aFifoWrite;
  wire bFifoRead;
  wire bLoad;
  wire bufWrReady;
  wire bufRdValid;
  wire [DATA_W-1:0] bufRdData;
  wire [ADDR_W:0] bufLevel;
  wire [ADDR_W+1:0] fullLimit;
  wire aMailHit;
  wire bMailHit;
  wire aMailWrite;
  wire aMailRead;
  wire bMailWrite;
  wire bMailRead;
  wire aLastSlot;
  wire next_irStage;

  // one port edge with its port selected and gated; FIFO writes and mailbox operations need all three, serial loading and the output-ready load only the edge
  function portHit;
    input edgeSeen;
    input selectN;
    input gate;
    begin
      portHit = edgeSeen && !selectN && gate;
    end
  endfunction

  // port clocks arrive as synchronous levels; their rising edges become enables
  assign aEdge = portAClock && !aClockPrev;
  assign bEdge = portBClock && !bClockPrev;

  assign aWriteCycle = portHit(aEdge, portASelectN, portAGate) && portAWriteNotRead && !portAMailSelect;
  assign aFifoWrite = aWriteCycle && inputReady && (initState == ST_RUN);
  assign bFifoRead = portHit(bEdge, portBSelectN, portBGate) && portBReadNotWrite
    && !portBMailSelect && outputReady;
  assign aMailHit = portHit(aEdge, portASelectN, portAGate) && portAMailSelect;
  assign bMailHit = portHit(bEdge, portBSelectN, portBGate) && portBMailSelect;
  assign aMailWrite = aMailHit && portAWriteNotRead;
  assign aMailRead = aMailHit && !portAWriteNotRead;
  assign bMailWrite = bMailHit && !portBReadNotWrite;
  assign bMailRead = bMailHit && portBReadNotWrite;
  // a selected read with a word waiting, or the word that raises output-ready
  assign bLoad = bufRdValid && ((bFifoRead) || (bEdge && !outputReady && orStage));
  assign fullLimit = DEPTH[ADDR_W+1:0] - {2'h0, fullOffset};
  // the write that takes the last free slot; a pop in the same cycle leaves one free
  assign aLastSlot = aFifoWrite && !bLoad && (bufLevel == DEPTH[ADDR_W:0] - 1'b1);
  assign next_irStage = bufWrReady && !aLastSlot;

  dcfm_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) storage (
    .clock(clock),
    .sys_rst(sys_rst),
    .wrValid(aFifoWrite),
    .wrData(portADataIn),
    .wrReady(bufWrReady),
    .rdValid(bufRdValid),
    .rdData(bufRdData),
    .rdReady(bLoad),
    .level(bufLevel)
  );

  // the history follows the pins through reset, so a port clock already high at release is no edge
  always @(posedge clock) begin
    aClockPrev <= portAClock;
    bClockPrev <= portBClock;
  end

  // strap capture is clocked; the last value seen in reset is the one at release
  always @(posedge clock) begin
    if (sys_rst) begin
      strap <= {offsetSel1SerialLoadN, offsetSel0SerialBit};
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      initState <= ST_WAIT;
      startEdges <= 2'h0;
      serialBits <= 5'h00;
      parallelDone <= 1'b0;
      emptyOffset <= `DCFM_OFS_RESET;
      fullOffset <= `DCFM_OFS_RESET;
    end else begin
      case (initState)
        ST_WAIT: begin
          if (strap == STRAP_SERIAL) begin
            initState <= ST_SERIAL;
          end else begin
            if (strap == STRAP_LOW) begin
              emptyOffset <= `DCFM_PRESET_LOW;
              fullOffset <= `DCFM_PRESET_LOW;
            end else if (strap == STRAP_HIGH) begin
              emptyOffset <= `DCFM_PRESET_HIGH;
              fullOffset <= `DCFM_PRESET_HIGH;
            end
            if (aEdge) begin
              startEdges <= startEdges + 2'h1;
            end
            if (aEdge && startEdges == `DCFM_START_EDGES - 2'h1) begin
              initState <= (strap == STRAP_PARALLEL) ? ST_PARALLEL : ST_RUN;
            end
          end
        end
        ST_SERIAL: begin
          if (aEdge && !offsetSel1SerialLoadN && serialBits != `DCFM_SERIAL_BITS) begin
            // one 18-bit shift chain: full offset MSB first, empty offset LSB last
            {fullOffset, emptyOffset} <= {fullOffset[`DCFM_OFS_W-2:0], emptyOffset, offsetSel0SerialBit};
            serialBits <= serialBits + 5'h01;
          end
          if (aEdge && serialBits == `DCFM_SERIAL_BITS) begin
            initState <= ST_RUN;
          end
        end
        ST_PARALLEL: begin
          if (aWriteCycle) begin
            if (!parallelDone) begin
              fullOffset <= portADataIn[`DCFM_OFS_W-1:0];
              parallelDone <= 1'b1;
            end else begin
              emptyOffset <= portADataIn[`DCFM_OFS_W-1:0];
              initState <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          initState <= ST_RUN;
        end
        default: begin
          initState <= ST_WAIT;
        end
      endcase
    end
  end

  // flags on the port A side, each stepped by a port A edge; almost-full takes two stages, input-ready two only when it rises in run or parallel
  always @(posedge clock) begin
    if (sys_rst) begin
      irStage <= 1'b0;
      inputReady <= 1'b0;
      afStage <= 1'b1;
      almostFullFlagN <= 1'b1;
    end else if (aEdge) begin
      irStage <= next_irStage;
      afStage <= ({1'b0, bufLevel} < fullLimit);
      almostFullFlagN <= afStage;
      if (initState == ST_RUN || initState == ST_PARALLEL) begin
        inputReady <= irStage && !aLastSlot;
      end else if (initState == ST_WAIT && startEdges == `DCFM_START_EDGES - 2'h1 && strap != STRAP_SERIAL) begin
        inputReady <= 1'b1;
      end else if (initState == ST_SERIAL && serialBits == `DCFM_SERIAL_BITS) begin
        inputReady <= 1'b1;
      end else begin
        inputReady <= 1'b0;
      end
    end
  end

  // flags on the port B side; a word in the output register has left the count
  always @(posedge clock) begin
    if (sys_rst) begin
      aeStage <= 1'b0;
      almostEmptyFlagN <= 1'b0;
      orStage <= 1'b0;
      outputReady <= 1'b0;
      outReg <= {DATA_W{1'b0}};
    end else if (bEdge) begin
      aeStage <= (bufLevel > {1'b0, emptyOffset});
      almostEmptyFlagN <= aeStage;
      orStage <= bufRdValid;
      if (bLoad) begin
        outReg <= bufRdData;
        outputReady <= 1'b1;
      end else if (bFifoRead) begin
        outputReady <= 1'b0;
      end
    end
  end

  // each mailbox has one writer port
  always @(posedge clock) begin
    if (sys_rst) begin
      mailToB <= {DATA_W{1'b0}};
    end else if (aMailWrite) begin
      mailToB <= portADataIn;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      mailToA <= {DATA_W{1'b0}};
    end else if (bMailWrite) begin
      mailToA <= portBDataIn;
    end
  end

  // new mail wins over a read in the same cycle, so a fresh word is never flagged as taken
  always @(posedge clock) begin
    if (sys_rst) begin
      mailToBFlagN <= 1'b1;
      mailToAFlagN <= 1'b1;
    end else begin
      if (aMailWrite) begin
        mailToBFlagN <= 1'b0;
      end else if (bMailRead) begin
        mailToBFlagN <= 1'b1;
      end
      if (bMailWrite) begin
        mailToAFlagN <= 1'b0;
      end else if (aMailRead) begin
        mailToAFlagN <= 1'b1;
      end
    end
  end

  // pin drive is registered, so enables follow the selects one system clock later
  always @(posedge clock) begin
    if (sys_rst) begin
      portADataOut <= {DATA_W{1'b0}};
      portADataOe <= 1'b0;
    end else begin
      portADataOut <= mailToA;
      portADataOe <= !portASelectN && !portAWriteNotRead;
    end
  end

  // port B shows the mail-to-B box or the output register, chosen by its mail select
  always @(posedge clock) begin
    if (sys_rst) begin
      portBDataOut <= {DATA_W{1'b0}};
      portBDataOe <= 1'b0;
    end else begin
      portBDataOut <= portBMailSelect ? mailToB : outReg;
      portBDataOe <= !portBSelectN && portBReadNotWrite;
    end
  end
endmodule

// ### verilog/dcfm_regs.vh
`ifndef DCFM_REGS_VH
`define DCFM_REGS_VH
`define DCFM_DATA_W 36
`define DCFM_DEPTH 512
`define DCFM_OFS_W 9
`define DCFM_SERIAL_BITS 5'h12
`define DCFM_PRESET_LOW 9'h008
`define DCFM_PRESET_HIGH 9'h040
`define DCFM_START_EDGES 2'h2
`define DCFM_OFS_RESET 9'h008
`endif

// ### verilog/dcfm_buffer.v
`timescale 1ns/1ps
module dcfm_buffer #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter ADDR_W = 3
) (
  input wire clock,
  input wire sys_rst,
  input wire wrValid,
  input wire [WIDTH-1:0] wrData,
  output wire wrReady,
  output wire rdValid,
  output wire [WIDTH-1:0] rdData,
  input wire rdReady,
  output wire [ADDR_W:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wrPtr;
  reg [ADDR_W-1:0] rdPtr;
  reg [ADDR_W:0] count;
  wire doWrite;
  wire doRead;
  assign wrReady = (count != DEPTH[ADDR_W:0]);
  assign rdValid = (count != {(ADDR_W+1){1'b0}});
  assign rdData = mem[rdPtr];
  assign level = count;
  assign doWrite = wrValid && wrReady;
  assign doRead = rdReady && rdValid;
  always @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr] <= wrData;
    end
  end
  always @(posedge clock) begin
    if (sys_rst) begin
      wrPtr <= {ADDR_W{1'b0}};
      rdPtr <= {ADDR_W{1'b0}};
      count <= {(ADDR_W+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### bench/dcfm_checker.sv
`timescale 1ns/1ps
module dcfm_checker (
  input wire clock,
  input wire sys_rst,
  input wire portAClock,
  input wire portBClock,
  input wire portASelectN,
  input wire portBSelectN,
  input wire portAWriteNotRead,
  input wire portBReadNotWrite,
  input wire portAGate,
  input wire portBGate,
  input wire portAMailSelect,
  input wire portBMailSelect,
  input wire inputReady,
  input wire outputReady,
  input wire almostEmptyFlagN,
  input wire almostFullFlagN,
  input wire mailToBFlagN,
  input wire mailToAFlagN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a port edge: the port clock high now and low at the system clock edge before
  sequence aEdge;
    portAClock && !$past(portAClock);
  endsequence
  sequence bEdge;
    portBClock && !$past(portBClock);
  endsequence
  sequence aMail;
    aEdge ##0 !portASelectN && portAGate && portAMailSelect;
  endsequence
  sequence bMail;
    bEdge ##0 !portBSelectN && portBGate && portBMailSelect;
  endsequence
  chk_reset_values: assert property ($fell(sys_rst) |-> !inputReady && !outputReady && !almostEmptyFlagN
    && almostFullFlagN && mailToBFlagN && mailToAFlagN) else $error("reset flag values wrong");
  chk_mail_to_b: assert property (aMail ##0 portAWriteNotRead |=> !mailToBFlagN)
    else $error("mail to b flag not set");
  // a mailbox write from the far port in the same cycle wins over the read
  chk_mail_a_read: assert property (aMail ##0 !portAWriteNotRead
    ##0 !(portBClock && !$past(portBClock) && !portBSelectN && portBGate && portBMailSelect && !portBReadNotWrite)
    |=> mailToAFlagN) else $error("mail to a flag not cleared");
  chk_mail_to_a: assert property (bMail ##0 !portBReadNotWrite |=> !mailToAFlagN)
    else $error("mail to a flag not set");
  chk_mail_b_read: assert property (bMail ##0 portBReadNotWrite
    ##0 !(portAClock && !$past(portAClock) && !portASelectN && portAGate && portAMailSelect && portAWriteNotRead)
    |=> mailToBFlagN) else $error("mail to b flag not cleared");
  chk_gate_idle: assert property (!portAGate && !portBGate |=> $stable(mailToBFlagN) && $stable(mailToAFlagN))
    else $error("mail flag moved with gates low");
  chk_b_flag_edge: assert property ($changed(outputReady) || $changed(almostEmptyFlagN)
    |-> $past(portBClock) && !$past(portBClock, 2)) else $error("b flag moved off a b edge");
  chk_a_flag_edge: assert property ($changed(inputReady) || $changed(almostFullFlagN)
    |-> $past(portAClock) && !$past(portAClock, 2)) else $error("a flag moved off an a edge");
endmodule
bind dcfm_top dcfm_checker i_chk (.clock(clock), .sys_rst(sys_rst), .portAClock(portAClock),
  .portBClock(portBClock), .portASelectN(portASelectN), .portBSelectN(portBSelectN),
  .portAWriteNotRead(portAWriteNotRead), .portBReadNotWrite(portBReadNotWrite), .portAGate(portAGate),
  .portBGate(portBGate), .portAMailSelect(portAMailSelect), .portBMailSelect(portBMailSelect),
  .inputReady(inputReady), .outputReady(outputReady), .almostEmptyFlagN(almostEmptyFlagN),
  .almostFullFlagN(almostFullFlagN), .mailToBFlagN(mailToBFlagN), .mailToAFlagN(mailToAFlagN));

// ### bench/dcfm_port_host.sv
`timescale 1ns/1ps
module dcfm_port_host #(
  parameter START = 2'h0
) (
  input wire clock,
  output reg portClock,
  input wire [35:0] hostData,
  input wire hostOe,
  input wire [35:0] devData,
  input wire devOe,
  output wire [35:0] pin
);
  reg [1:0] phase = START;
  reg [35:0] last = 36'h0;
  initial portClock = 1'b0;
  // free-running port clock, one rising edge every four system clocks
  always @(posedge clock) begin
    phase <= phase + 2'h1;
    portClock <= phase[1];
    last <= pin;
  end
  // a released bus never keeps the last value, so a missed drive shows up
  assign pin = devOe ? devData : hostOe ? hostData : ~last;
endmodule

// ### bench/test_dcfm_top.sv
`timescale 1ns/1ps
module test_dcfm_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic aSelN = 1'b1, aWr = 1'b0, aGate = 1'b0, aMail = 1'b0, sd = 1'b0, senN = 1'b1;
  logic bSelN = 1'b1, bRd = 1'b0, bGate = 1'b0, bMail = 1'b0;
  logic [35:0] aHost = 36'h0, bHost = 36'h0, aOut, bOut, aPin, bPin, aSeen, bSeen;
  logic aOe, bOe, aClk, bClk, ir, orf, aeN, afN, mbN, maN;
  int errors = 0;
  int compares = 0;
  dcfm_port_host #(.START(2'h0)) i_host_a (.clock(clock), .portClock(aClk), .hostData(aHost), .hostOe(aWr),
    .devData(aOut), .devOe(aOe), .pin(aPin));
  dcfm_port_host #(.START(2'h1)) i_host_b (.clock(clock), .portClock(bClk), .hostData(bHost), .hostOe(!bRd),
    .devData(bOut), .devOe(bOe), .pin(bPin));
  dcfm_top i_dut (.clock(clock), .sys_rst(sys_rst), .portAClock(aClk), .portBClock(bClk), .portASelectN(aSelN),
    .portBSelectN(bSelN), .portAWriteNotRead(aWr), .portBReadNotWrite(bRd), .portAGate(aGate), .portBGate(bGate),
    .portAMailSelect(aMail), .portBMailSelect(bMail), .offsetSel0SerialBit(sd), .offsetSel1SerialLoadN(senN),
    .portADataIn(aPin), .portADataOut(aOut), .portADataOe(aOe), .portBDataIn(bPin), .portBDataOut(bOut),
    .portBDataOe(bOe), .inputReady(ir), .outputReady(orf), .almostEmptyFlagN(aeN), .almostFullFlagN(afN),
    .mailToBFlagN(mbN), .mailToAFlagN(maN));
  initial forever #2.5 clock = ~clock;
  task automatic final_report;
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // c is {select_n, write or read, gate, mail, serial bit, serial load_n}; held across exactly one port edge
  task automatic op(input logic b, input logic [5:0] c, input logic [35:0] d);
    @(posedge clock);
    #1;
    while ((b ? bClk : aClk) !== 1'b0) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    if (b) {bSelN, bRd, bGate, bMail, bHost} <= {c[5:2], d};
    else {aSelN, aWr, aGate, aMail, sd, senN, aHost} <= {c, d};
    repeat (3) @(posedge clock);
    #1;
    aSeen = aPin;
    bSeen = bPin;
    @(posedge clock);
    if (b) {bSelN, bRd, bGate, bMail} <= 4'b1000;
    else {aSelN, aWr, aGate, aMail, sd, senN} <= 6'b100001;
    #1;
  endtask
  task automatic do_reset(input logic s0, input logic s1);
    @(posedge clock);
    {sys_rst, sd, senN} <= {1'b1, s0, s1};
    repeat (20) @(posedge clock);
    {sys_rst, sd, senN} <= 3'b001;
    #1;
    chk("reset flags", 36'h7, {30'h0, ir, orf, aeN, afN, mbN, maN});
  endtask
  task automatic fill(input int n, input logic [35:0] base);
    for (int i = 0; i < n; i++) op(1'b0, 6'b011001, base + 36'(i));
    repeat (40) @(posedge clock);
    #1;
  endtask
  task automatic t_preset;
    do_reset(1'b1, 1'b0);
    repeat (12) @(posedge clock);
    #1;
    chk("input ready", 36'h1, {35'h0, ir});
    op(1'b0, 6'b011001, 36'h100);
    chk("a bus released", 36'h100, aSeen);
    fill(4, 36'h101);
    chk("almost empty low", 36'h0, {35'h0, aeN});
    fill(5, 36'h105);
    chk("almost empty high", 36'h3, {34'h0, aeN, afN});
    chk("output ready", 36'h1, {35'h0, orf});
    op(1'b1, 6'b010000, 36'h0);
    chk("first word", 36'h100, bSeen);
    op(1'b1, 6'b011000, 36'h0);
    chk("second word", 36'h101, bSeen);
  endtask
  task automatic t_mail;
    op(1'b0, 6'b010101, 36'h123456789);
    chk("gated mail flag", 36'h1, {35'h0, mbN});
    op(1'b0, 6'b011101, 36'h123456789);
    chk("mail to b flag", 36'h0, {35'h0, mbN});
    op(1'b1, 6'b011100, 36'h0);
    chk("mail to b data", 36'h123456789, bSeen);
    chk("mail to b read", 36'h1, {35'h0, mbN});
    op(1'b1, 6'b001100, 36'h0abcdef01);
    chk("b bus released", 36'h0abcdef01, bSeen);
    chk("mail to a flag", 36'h0, {35'h0, maN});
    op(1'b0, 6'b001101, 36'h0);
    chk("mail to a data", 36'h0abcdef01, aSeen);
    chk("mail to a read", 36'h1, {35'h0, maN});
  endtask
  task automatic t_parallel;
    do_reset(1'b0, 1'b0);
    repeat (12) @(posedge clock);
    #1;
    chk("input ready", 36'h1, {35'h0, ir});
    op(1'b0, 6'b011001, 36'hffffffff4);
    op(1'b0, 6'b011001, 36'hffffffe03);
    fill(5, 36'h200);
    chk("offsets loaded", 36'h3, {34'h0, aeN, afN});
    fill(9, 36'h205);
    chk("almost full low", 36'h2, {34'h0, aeN, afN});
    op(1'b1, 6'b010000, 36'h0);
    chk("offset writes not stored", 36'h200, bSeen);
  endtask
  task automatic t_serial;
    logic [17:0] chain;
    chain = {9'd500, 9'd3};
    do_reset(1'b1, 1'b1);
    for (int i = 17; i >= 0; i--) begin
      if (i == 0) chk("ready before last bit", 36'h0, {35'h0, ir});
      op(1'b0, {4'b1000, chain[i], 1'b0}, 36'h0);
    end
    repeat (8) @(posedge clock);
    #1;
    chk("ready after last bit", 36'h1, {35'h0, ir});
    fill(14, 36'h300);
    chk("serial offsets", 36'h2, {34'h0, aeN, afN});
  endtask
  initial begin
    t_preset;
    t_mail;
    t_parallel;
    t_serial;
    final_report;
  end
  initial begin
    #100000;
    errors++;
    final_report;
  end
endmodule
